//--- dv/rrw_link_props.sv
/* Assertions on the controller-sensor link signals.
   Assumes one clock domain; instantiated beside the link interface. */
`timescale 1ns/1ps
module rrw_link_props (
    input wire logic                       clock_in,
    input wire logic                       rst_b_in,
    input wire logic                       cfg_wr,
    input wire logic [rrw_pkg::CFG_AW-1:0] cfg_addr,
    input wire logic                       frame_begin,
    input wire logic                       row_advance,
    input wire logic                       pix_valid,
    input wire logic                       pix_ready,
    input wire logic [rrw_pkg::PIX_W-1:0]  pix_data,
    input wire logic [rrw_pkg::CLS_W-1:0]  pix_class
);
    logic [9:0] since_row_r;
    logic [1:0] last_cls_r;
    logic       mid_row_r;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // Saturating age of the last row pulse; saturation hides stale gaps
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            since_row_r <= 10'h000;
            last_cls_r  <= 2'h0;
            mid_row_r   <= 1'b0;
        end else begin
            if (row_advance) since_row_r <= 10'h001;
            else if (since_row_r != 10'h3FF)
                since_row_r <= since_row_r + 10'h001;
            if (row_advance) mid_row_r <= 1'b0;
            else if (pix_valid && pix_ready) mid_row_r <= 1'b1;
            if (pix_valid && pix_ready) last_cls_r <= pix_class;
        end
    end
    // Rest of the start-up write burst
    sequence s_cfg_rest;
        cfg_wr && cfg_addr == rrw_pkg::CFG_COL_START ##1
        cfg_wr && cfg_addr == rrw_pkg::CFG_MUX ##1
        cfg_wr && cfg_addr == rrw_pkg::CFG_LINE_LEN ##1
        !cfg_wr && frame_begin;
    endsequence
    sequence s_take;
        pix_valid && pix_ready;
    endsequence
    a_cfg_burst_order: assert property (
        cfg_wr && cfg_addr == rrw_pkg::CFG_ROW_START |=> s_cfg_rest)
        else $error("config burst out of order");
    a_frame_then_row: assert property (
        frame_begin |=> row_advance && !frame_begin)
        else $error("no row pulse after frame pulse");
    a_row_pulse_single: assert property (
        row_advance |=> !row_advance)
        else $error("row pulse longer than one cycle");
    a_blank_before_pix: assert property (
        pix_valid |-> since_row_r >= 10'h2D0)
        else $error("pixel offered inside row blanking");
    a_blank_quiet: assert property (
        row_advance |=> !pix_valid [*8])
        else $error("pixel right after row pulse");
    a_word_held: assert property (
        pix_valid && !pix_ready |=>
            pix_valid && $stable(pix_data) && $stable(pix_class))
        else $error("stalled word changed or dropped");
    a_pix_pace: assert property (
        s_take |=> !pix_ready [*2])
        else $error("pixel taken faster than pixel period");
    a_take_bound: assert property (
        pix_valid |-> ##[0:3] pix_ready)
        else $error("offered pixel not taken in time");
    a_class_step: assert property (
        s_take |-> (mid_row_r ?
            pix_class == {last_cls_r[1], ~last_cls_r[0]} : !pix_class[0]))
        else $error("colour class out of step");
endmodule

//--- dv/testbench.sv
/* Self-checking bench joining controller and sensor ends over the link.
   Assumes the package and interface are compiled first. */
`timescale 1ns/1ps
module testbench;
    logic                         clock_in     = 1'b0;
    logic                         rst_b_in     = 1'b0;
    logic                         start_in     = 1'b0;
    logic                         mux_one_in   = 1'b0;
    logic                         nondestr_in  = 1'b0;
    logic [rrw_pkg::ROW_W-1:0]    row_start_in = 12'h000;
    logic [rrw_pkg::COLI_W-1:0]   col_idx_in   = 7'h00;
    logic [rrw_pkg::ROW_W-1:0]    line_len_in  = 12'h001;
    logic [rrw_pkg::ROW_W-1:0]    lines_in     = 12'h001;
    logic [rrw_pkg::PIX_W-1:0]    adc_even_in  = 10'h2AA;
    logic [rrw_pkg::PIX_W-1:0]    adc_odd_in   = 10'h155;
    logic                         frame_done_out;
    logic                         pix_valid_out;
    logic [rrw_pkg::PIX_W-1:0]    pix_data_out;
    logic [rrw_pkg::CLS_W-1:0]    pix_class_out;
    logic [rrw_pkg::ROW_W-1:0]    row_addr_out;
    logic [rrw_pkg::ROW_W-1:0]    col_addr_out;
    logic                         calib_out;
    logic                         bus_ref_out;
    logic                         busy_out;
    int                           miscompares  = 0;
    int                           num_checks   = 0;
    int                           cycles       = 0;

    rrw_link_if i_rrw_link_if ();
    rrw_sensor_seq i_rrw_sensor_seq (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .link(i_rrw_link_if),
        .adc_even_in(adc_even_in), .adc_odd_in(adc_odd_in),
        .nondestructive_readout_in(nondestr_in), .row_addr_out(row_addr_out),
        .col_addr_out(col_addr_out), .calib_out(calib_out),
        .bus_ref_out(bus_ref_out));
    rrw_cam_ctl i_rrw_cam_ctl (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .link(i_rrw_link_if),
        .start_in(start_in), .row_start_in(row_start_in),
        .col_idx_in(col_idx_in), .mux_one_in(mux_one_in),
        .line_len_in(line_len_in), .lines_in(lines_in), .busy_out(busy_out),
        .frame_done_out(frame_done_out), .pix_valid_out(pix_valid_out),
        .pix_data_out(pix_data_out), .pix_class_out(pix_class_out));
    rrw_link_props i_rrw_link_props (
        .clock_in(clock_in), .rst_b_in(rst_b_in),
        .cfg_wr(i_rrw_link_if.cfg_wr), .cfg_addr(i_rrw_link_if.cfg_addr),
        .frame_begin(i_rrw_link_if.frame_begin),
        .row_advance(i_rrw_link_if.row_advance),
        .pix_valid(i_rrw_link_if.pix_valid),
        .pix_ready(i_rrw_link_if.pix_ready),
        .pix_data(i_rrw_link_if.pix_data),
        .pix_class(i_rrw_link_if.pix_class));

    // 100 MHz clock
    always #5 clock_in = ~clock_in;
    // Hang guard; frames here need well under 10000 cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp,
            input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bayer class from row and column parity
    function automatic logic [1:0] cls_of(input logic r, input logic c);
        if (r) return c ? rrw_pkg::CLS_GREEN1 : rrw_pkg::CLS_BLUE;
        return c ? rrw_pkg::CLS_RED : rrw_pkg::CLS_GREEN2;
    endfunction

    // Drives one frame, then judges pointers, blanking and every pixel
    task automatic run_frame(input logic [11:0] rs, input logic [6:0] ci,
            input logic mx, input logic [11:0] len, input logic [11:0] lns,
            input logic [11:0] ers, input logic [6:0] eci,
            input logic [11:0] elen);
        int          n;
        int          ln;
        int          cal;
        logic        was_cal;
        logic [11:0] row;
        logic [11:0] col;
        n = 0;
        ln = 0;
        cal = 0;
        was_cal = 1'b0;
        row = ers;
        @(negedge clock_in);
        row_start_in = rs;
        col_idx_in = ci;
        mux_one_in = mx;
        line_len_in = len;
        lines_in = lns;
        start_in = 1'b1;
        @(negedge clock_in);
        start_in = 1'b0;
        while (frame_done_out !== 1'b1) begin
            @(negedge clock_in);
            if (calib_out === 1'b1 && !was_cal) begin
                row = ers + 12'(ln);
                ln++;
                cal = 0;
                chk("row_addr", row, row_addr_out);
                chk("col_addr", 12'(eci) * 12'h018, col_addr_out);
                chk("busy", 12'h001, 12'(busy_out));
            end
            if (calib_out === 1'b1) begin
                cal++;
                chk("bus_ref", 12'h001, 12'(bus_ref_out));
            end
            if (calib_out !== 1'b1 && was_cal)
                chk("calib_len", 12'h2D0, 12'(cal));
            was_cal = (calib_out === 1'b1);
            if (pix_valid_out === 1'b1) begin
                col = 12'(eci) * 12'h018 + 12'(n % int'(elen));
                chk("pix_data", 12'((col[0] && !mx) ? adc_odd_in
                    : adc_even_in), 12'(pix_data_out));
                chk("pix_class", 12'(cls_of(row[0], col[0])),
                    12'(pix_class_out));
                n++;
            end
        end
        chk("pix_count", elen * lns, 12'(n));
        chk("busy", 12'h000, 12'(busy_out));
    endtask

    // Bus reference follows the readout mode input while idle
    task automatic t_nondestr();
        nondestr_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk("bus_ref_hold", 12'h001, 12'(bus_ref_out));
        nondestr_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk("bus_ref_idle", 12'h000, 12'(bus_ref_out));
        $display("test nondestr done");
    endtask

    initial begin
        repeat (5) @(negedge clock_in);
        rst_b_in = 1'b1;
        run_frame(12'h000, 7'h00, 1'b0, 12'h006, 12'h002,
            12'h000, 7'h00, 12'h006);
        $display("test window_basic done");
        run_frame(12'hBB9, 7'h62, 1'b1, 12'h003, 12'h002,
            12'hBB9, 7'h62, 12'h003);
        $display("test far_corner done");
        // Out-of-range starts leave stored values; zero length goes out as length 1
        run_frame(12'hBBA, 7'h63, 1'b0, 12'h000, 12'h001,
            12'hBB9, 7'h62, 12'h001);
        $display("test refused_start done");
        t_nondestr();
        results();
    end
endmodule

//--- logic/rrw_buf2.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes a single clock; output data comes straight from flip-flops.
 */
`timescale 1ns/1ps
module rrw_buf2 #(
    parameter int W = 12
) (
    input  wire logic         clock_in,
    input  wire logic         rst_b_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    typedef struct packed {
        logic [1:0]   cnt;
        logic [W-1:0] head;
        logic [W-1:0] tail;
    } rrw_buf_t;

    rrw_buf_t st_r;
    rrw_buf_t st_nxt;
    logic     push;
    logic     pop;

    // Full at two entries, so a stall never drops a word
    assign in_ready_out  = (st_r.cnt != 2'h2);
    assign out_valid_out = (st_r.cnt != 2'h0);
    assign out_data_out  = st_r.head;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Head is the oldest word, tail the second
    always_comb begin
        st_nxt = st_r;
        if (pop) begin
            st_nxt.head = st_r.tail;
        end
        if (push) begin
            if (st_r.cnt == 2'h0 || (st_r.cnt == 2'h1 && pop)) begin
                st_nxt.head = in_data_in;
            end else begin
                st_nxt.tail = in_data_in;
            end
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

//--- logic/rrw_cam_ctl.sv
/*
 * Controller end: writes start points, mux and line length, then
 * drives one frame pulse and a row pulse per line, taking pixels
 * no faster than one per pixel period.
 * Assumes the sensor end on the other modport of the shared link.
 */
`timescale 1ns/1ps
module rrw_cam_ctl (
    input  wire logic                       clock_in,
    input  wire logic                       rst_b_in,
    rrw_link_if.ctl                         link,
    input  wire logic                       start_in,
    input  wire logic [rrw_pkg::ROW_W-1:0]  row_start_in,
    input  wire logic [rrw_pkg::COLI_W-1:0] col_idx_in,
    input  wire logic                       mux_one_in,
    input  wire logic [rrw_pkg::ROW_W-1:0]  line_len_in,
    input  wire logic [rrw_pkg::ROW_W-1:0]  lines_in,
    output logic                            busy_out,
    output logic                            frame_done_out,
    output logic                            pix_valid_out,
    output logic [rrw_pkg::PIX_W-1:0]       pix_data_out,
    output logic [rrw_pkg::CLS_W-1:0]       pix_class_out
);
    typedef struct packed {
        rrw_pkg::rrw_hst_st_t       state;
        logic [1:0]                 step;
        logic [rrw_pkg::ROW_W-1:0]  row_start;
        logic [rrw_pkg::COLI_W-1:0] col_idx;
        logic                       mux_one;
        logic [rrw_pkg::ROW_W-1:0]  line_len;
        logic [rrw_pkg::ROW_W-1:0]  lines;
        logic [rrw_pkg::ROW_W-1:0]  line_cnt;
        logic [rrw_pkg::ROW_W-1:0]  pix_cnt;
        logic [1:0]                 pace;
        logic                       done;
        logic                       pv;
        logic [rrw_pkg::PIX_W-1:0]  pd;
        logic [rrw_pkg::CLS_W-1:0]  pc;
    } rrw_hst_t;

    rrw_hst_t st_r;
    rrw_hst_t st_nxt;
    logic     take;

    // one configuration write per cycle during setup
    assign link.cfg_wr   = (st_r.state == rrw_pkg::HST_CFG);
    assign link.cfg_addr = st_r.step;
    always_comb begin
        unique case (st_r.step)
            rrw_pkg::CFG_ROW_START: link.cfg_data = st_r.row_start;
            rrw_pkg::CFG_COL_START:
                link.cfg_data = {5'h00, st_r.col_idx};
            rrw_pkg::CFG_MUX: link.cfg_data = {11'h000, st_r.mux_one};
            rrw_pkg::CFG_LINE_LEN: link.cfg_data = st_r.line_len;
        endcase
    end
    assign link.frame_begin = (st_r.state == rrw_pkg::HST_FRAME);
    assign link.row_advance = (st_r.state == rrw_pkg::HST_ROW);
    // at most one pixel per pixel period
    assign link.pix_ready   = (st_r.state == rrw_pkg::HST_RECV) &&
                              (st_r.pace == '0);
    assign take = link.pix_ready && link.pix_valid;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        st_nxt.pv   = 1'b0;
        if (st_r.pace != '0) begin
            st_nxt.pace = st_r.pace - 1'b1;
        end
        unique case (st_r.state)
            rrw_pkg::HST_IDLE: begin
                if (start_in) begin
                    st_nxt.state     = rrw_pkg::HST_CFG;
                    st_nxt.step      = '0;
                    st_nxt.row_start = row_start_in;
                    st_nxt.col_idx   = col_idx_in;
                    st_nxt.mux_one   = mux_one_in;
                    st_nxt.line_len  = (line_len_in == '0) ?
                                       12'h001 : line_len_in;
                    st_nxt.lines     = (lines_in == '0) ?
                                       12'h001 : lines_in;
                end
            end
            rrw_pkg::HST_CFG: begin
                st_nxt.step = st_r.step + 1'b1;
                if (st_r.step == 2'h3) begin
                    st_nxt.state = rrw_pkg::HST_FRAME;
                end
            end
            rrw_pkg::HST_FRAME: begin
                st_nxt.state    = rrw_pkg::HST_ROW;
                st_nxt.line_cnt = '0;
            end
            rrw_pkg::HST_ROW: begin
                st_nxt.state   = rrw_pkg::HST_RECV;
                st_nxt.pix_cnt = '0;
            end
            rrw_pkg::HST_RECV: begin
                // no pixel arrives until blanking has ended
                // frame time is lines of blanking plus pixels
                if (take) begin
                    st_nxt.pace    = 2'(rrw_pkg::PIX_CYC - 1);
                    st_nxt.pv      = 1'b1;
                    st_nxt.pd      = link.pix_data;
                    st_nxt.pc      = link.pix_class;
                    st_nxt.pix_cnt = st_r.pix_cnt + 1'b1;
                    if (st_r.pix_cnt == st_r.line_len - 1'b1) begin
                        st_nxt.line_cnt = st_r.line_cnt + 1'b1;
                        if (st_r.line_cnt == st_r.lines - 1'b1) begin
                            st_nxt.state = rrw_pkg::HST_IDLE;
                            st_nxt.done  = 1'b1;
                        end else begin
                            // next row opens with a row pulse
                            st_nxt.state = rrw_pkg::HST_ROW;
                        end
                    end
                end
            end
            default: st_nxt.state = rrw_pkg::HST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r       <= '0;
            st_r.state <= rrw_pkg::HST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_out       = (st_r.state != rrw_pkg::HST_IDLE);
    assign frame_done_out = st_r.done;
    assign pix_valid_out  = st_r.pv;
    assign pix_data_out   = st_r.pd;
    assign pix_class_out  = st_r.pc;
endmodule

//--- logic/rrw_link_if.sv
/*
 * Link between the camera controller and the sensor sequencer:
 * configuration writes, frame and row pulses, and the pixel stream.
 * Assumes both ends share clock_in; the bench joins the two modports.
 */
`timescale 1ns/1ps
interface rrw_link_if;
    logic                       cfg_wr;
    logic [rrw_pkg::CFG_AW-1:0] cfg_addr;
    logic [rrw_pkg::CFG_DW-1:0] cfg_data;
    logic                       frame_begin;
    logic                       row_advance;
    logic                       pix_valid;
    logic                       pix_ready;
    logic [rrw_pkg::PIX_W-1:0]  pix_data;
    logic [rrw_pkg::CLS_W-1:0]  pix_class;

    modport dev (
        input  cfg_wr, cfg_addr, cfg_data, frame_begin, row_advance,
        input  pix_ready,
        output pix_valid, pix_data, pix_class
    );
    modport ctl (
        output cfg_wr, cfg_addr, cfg_data, frame_begin, row_advance,
        output pix_ready,
        input  pix_valid, pix_data, pix_class
    );
endinterface

//--- logic/rrw_pkg.sv
/*
 * Shared constants and types for the rolling readout window sequencer:
 * configuration addresses, field widths, reset values, colour classes,
 * timing counts and the state encodings of both ends.
 * Assumes a single 100 MHz clock for the whole link.
 */
package rrw_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROW_BLANK_NS  = 7200;  // row_blanking_interval, typical
    localparam int PIX_PERIOD_NS = 25;    // one pixel at 40 MHz
    // Least times round up to whole cycles
    localparam int ROW_BLANK_CYC =
        (ROW_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIX_CYC =
        (PIX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths
    localparam int CFG_AW  = 2;
    localparam int CFG_DW  = 12;
    localparam int ROW_W   = 12;
    localparam int COLI_W  = 7;
    localparam int PIX_W   = 10;
    localparam int CLS_W   = 2;
    localparam int BLANK_W = 10;

    // Configuration addresses on the shared address/data bus
    localparam logic [CFG_AW-1:0] CFG_ROW_START = 2'h0;
    localparam logic [CFG_AW-1:0] CFG_COL_START = 2'h1;
    localparam logic [CFG_AW-1:0] CFG_MUX       = 2'h2;
    localparam logic [CFG_AW-1:0] CFG_LINE_LEN  = 2'h3;

    // Start point limits; column start is a 24-pixel block index
    localparam logic [ROW_W-1:0]  ROW_POS_MAX = 12'hBB9; // line 3001
    localparam logic [COLI_W-1:0] COL_POS_MAX = 7'h62;   // block 98

    // Reset values
    localparam logic [ROW_W-1:0]  ROW_START_RST = 12'h000;
    localparam logic [COLI_W-1:0] COL_START_RST = 7'h00;
    localparam logic              MUX_RST       = 1'h0;  // interleave
    localparam logic [ROW_W-1:0]  LINE_LEN_RST  = 12'h8A2; // 2210

    // Colour filter classes
    localparam logic [CLS_W-1:0] CLS_GREEN2 = 2'h0; // green on green-red
    localparam logic [CLS_W-1:0] CLS_RED    = 2'h1;
    localparam logic [CLS_W-1:0] CLS_BLUE   = 2'h2;
    localparam logic [CLS_W-1:0] CLS_GREEN1 = 2'h3; // green on blue-green

    typedef enum logic [1:0] {
        DEV_IDLE  = 2'b00,
        DEV_CALIB = 2'b01,
        DEV_READ  = 2'b10
    } rrw_dev_st_t;

    typedef enum logic [2:0] {
        HST_IDLE  = 3'b000,
        HST_CFG   = 3'b001,
        HST_FRAME = 3'b010,
        HST_ROW   = 3'b011,
        HST_RECV  = 3'b100
    } rrw_hst_st_t;
endpackage

//--- logic/rrw_sensor_seq.sv
/*
 * Sensor end: stores start points and mux setting, loads the row and
 * column shift registers on frame and row pulses, runs the column
 * calibration blanking and streams converter samples with colour class.
 * Assumes the controller keeps its own timing; converters feed adc_*_in.
 */


`timescale 1ns/1ps
module rrw_sensor_seq (
    input  wire logic                     clock_in,
    input  wire logic                     rst_b_in,
    rrw_link_if.dev                       link,
    input  wire logic [rrw_pkg::PIX_W-1:0] adc_even_in,
    input  wire logic [rrw_pkg::PIX_W-1:0] adc_odd_in,
    input  wire logic                     nondestructive_readout_in,
    output logic [rrw_pkg::ROW_W-1:0]     row_addr_out,
    output logic [rrw_pkg::ROW_W-1:0]     col_addr_out,
    output logic                          calib_out,
    output logic                          bus_ref_out
);
    // Class above sample
    localparam int BW = rrw_pkg::PIX_W + rrw_pkg::CLS_W;

    typedef struct packed {
        rrw_pkg::rrw_dev_st_t        state;
        logic [rrw_pkg::ROW_W-1:0]   row_start;
        logic [rrw_pkg::COLI_W-1:0]  col_idx;
        logic                        mux_one;
        logic [rrw_pkg::ROW_W-1:0]   line_len;
        logic [rrw_pkg::ROW_W-1:0]   row_ptr;
        logic [rrw_pkg::ROW_W-1:0]   col_ptr;
        logic                        first_row;
        logic [rrw_pkg::BLANK_W-1:0] blank_cnt;
        logic [rrw_pkg::ROW_W-1:0]   pix_cnt;
        logic                        bus_ref;
    } rrw_dev_t;

    rrw_dev_t                   st_r;
    rrw_dev_t                   st_nxt;
    logic                       buf_ready;
    logic                       push;
    logic [rrw_pkg::PIX_W-1:0]  sample;
    logic [rrw_pkg::CLS_W-1:0]  cls;
    logic [rrw_pkg::ROW_W-1:0]  col_base;

    // column start is a block index times 24
    assign col_base = {st_r.col_idx, 5'h00} - {2'h0, st_r.col_idx, 3'h0};

    // even columns from one converter, odd from the other
    // single-output setting routes the even converter for all
    always_comb begin
        if (st_r.mux_one || !st_r.col_ptr[0]) begin
            sample = adc_even_in;
        end else begin
            sample = adc_odd_in;
        end
    end

    // origin is green on a green-red row
    always_comb begin
        unique case ({st_r.row_ptr[0], st_r.col_ptr[0]})
            2'b00: cls = rrw_pkg::CLS_GREEN2;
            2'b01: cls = rrw_pkg::CLS_RED;
            2'b10: cls = rrw_pkg::CLS_BLUE;
            2'b11: cls = rrw_pkg::CLS_GREEN1;
        endcase
    end

    // Push when buffer has room
    assign push = (st_r.state == rrw_pkg::DEV_READ) && buf_ready;

    // Sequencer: all progress hangs on the controller's pulses
    always_comb begin
        st_nxt = st_r;

        // configuration writes land in stored start points, mux and line length only
        if (link.cfg_wr) begin
            unique case (link.cfg_addr)
                rrw_pkg::CFG_ROW_START: begin
                    if (link.cfg_data <= rrw_pkg::ROW_POS_MAX) begin
                        st_nxt.row_start = link.cfg_data;
                    end
                end
                rrw_pkg::CFG_COL_START: begin
                    // column block index limited to legal range
                    if (link.cfg_data[rrw_pkg::CFG_DW-1:rrw_pkg::COLI_W]
                            == '0 &&
                        link.cfg_data[rrw_pkg::COLI_W-1:0]
                            <= rrw_pkg::COL_POS_MAX) begin
                        st_nxt.col_idx =
                            link.cfg_data[rrw_pkg::COLI_W-1:0];
                    end
                end
                // mux setting over the shared bus
                rrw_pkg::CFG_MUX: st_nxt.mux_one = link.cfg_data[0];
                rrw_pkg::CFG_LINE_LEN: begin
                    // A zero length would end a row only after 4096 pixels
                    if (link.cfg_data != '0) begin
                        st_nxt.line_len = link.cfg_data;
                    end
                end
            endcase
        end

        unique case (st_r.state)
            rrw_pkg::DEV_IDLE: begin
                // Wait for a row pulse
            end
            rrw_pkg::DEV_CALIB: begin
                st_nxt.blank_cnt = st_r.blank_cnt - 1'b1;
                if (st_r.blank_cnt == '0) begin
                    st_nxt.state   = rrw_pkg::DEV_READ;
                    st_nxt.pix_cnt = '0;
                end
            end
            rrw_pkg::DEV_READ: begin
                // Stall while the buffer is full; no word lost
                if (push) begin
                    st_nxt.col_ptr = st_r.col_ptr + 1'b1;
                    st_nxt.pix_cnt = st_r.pix_cnt + 1'b1;
                    if (st_r.pix_cnt == st_r.line_len - 1'b1) begin
                        st_nxt.state = rrw_pkg::DEV_IDLE;
                    end
                end
            end
            // Code 2'b11 unused
            default: st_nxt.state = rrw_pkg::DEV_IDLE;
        endcase

        // Pulses win
        // frame pulse loads the row shift register
        // stored start point applied only here
        if (link.frame_begin) begin
            st_nxt.row_ptr   = st_r.row_start;
            st_nxt.first_row = 1'b1;
            st_nxt.state     = rrw_pkg::DEV_IDLE;
        end else if (link.row_advance) begin
            // rows are selected only by the external pulse
            if (!st_r.first_row) begin
                st_nxt.row_ptr = st_r.row_ptr + 1'b1;
            end
            st_nxt.first_row = 1'b0;
            // row advance loads the column shift register
            // column start applied at the pulse only
            st_nxt.col_ptr   = col_base;
            st_nxt.state     = rrw_pkg::DEV_CALIB;
            st_nxt.blank_cnt =
                rrw_pkg::BLANK_W'(rrw_pkg::ROW_BLANK_CYC - 1);
        end

        // reference in blanking, always in nondestructive mode
        st_nxt.bus_ref = (st_nxt.state == rrw_pkg::DEV_CALIB) ||
                         nondestructive_readout_in;
    end

    // Defaults for stored values
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r           <= '0;
            st_r.state     <= rrw_pkg::DEV_IDLE;
            st_r.row_start <= rrw_pkg::ROW_START_RST;
            st_r.col_idx   <= rrw_pkg::COL_START_RST;
            st_r.mux_one   <= rrw_pkg::MUX_RST;
            st_r.line_len  <= rrw_pkg::LINE_LEN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pixel path buffered so a stall by the controller loses nothing
    rrw_buf2 #(
        .W (BW)
    ) u_buf (
        .clock_in      (clock_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (push),
        .in_ready_out  (buf_ready),
        .in_data_in    ({cls, sample}),
        .out_valid_out (link.pix_valid),
        .out_ready_in  (link.pix_ready),
        .out_data_out  ({link.pix_class, link.pix_data})
    );

    // Shift register positions and calibration state
    assign row_addr_out = st_r.row_ptr;
    assign col_addr_out = st_r.col_ptr;
    assign calib_out    = (st_r.state == rrw_pkg::DEV_CALIB);
    assign bus_ref_out  = st_r.bus_ref;
endmodule
